// ===== core/hbwu_defs.svh
// Behaviour
// - A data watchpoint hit loads the hit data register with the effective address.
// - A resource watchpoint hit loads the hit data register with the resource identifier.
// - Outside debug mode every thread with its stop bit set is held.
// - After leaving debug mode, threads marked in the stop vector stay held.
// - Eight scratch words, readable and writable, also reachable through the tile config port.
// - Four instruction breakpoints with address; enabled PC match raises a debug interrupt.
// - Breakpoint control bit 0 enables; bit 1 selects equal or not equal.
// - Breakpoint control bits 23:16 enable per thread; control fields reset to zero.
// - Four data watchpoints, each with a first and second address.
// - Data watchpoint control bit 0 enables, bits 23:16 per-thread enable, reset zero.
// - Data watchpoint control bit 1: zero needs A and B, one needs A or B.
// - Data watchpoint control bit 2 makes loads trigger the watchpoint too.
// - Four resource watchpoints, each with a mask and a value register.
// - Resource control bit 0 enables, bits 23:16 per thread, bit 1 selects equal or not equal.
// - Cause code recorded: 3 instruction breakpoint, 4 data watch, 5 resource watch.
// - Record hit index and thread number; simultaneous hits of one kind report the lowest index.
`ifndef HBWU_DEFS_SVH
`define HBWU_DEFS_SVH
`define HBWU_IDX_HIT_TYPE 8'h15
`define HBWU_IDX_HIT_DATA 8'h16
`define HBWU_IDX_CORE_STOP 8'h18
`define HBWU_IDX_SCRATCH 8'h20
`define HBWU_IDX_IB_ADDR 8'h30
`define HBWU_IDX_IB_CTRL 8'h40
`define HBWU_IDX_DW_A1 8'h50
`define HBWU_IDX_DW_A2 8'h60
`define HBWU_IDX_DW_CTRL 8'h70
`define HBWU_IDX_RW_MASK 8'h80
`define HBWU_IDX_RW_VAL 8'h90
`define HBWU_IDX_RW_CTRL 8'h9C
`define HBWU_IDX_IRQ_STAT 8'hA0
`define HBWU_IDX_IRQ_CLR 8'hA1
`define HBWU_IDX_IRQ_EN 8'hA2
`define HBWU_BIT_EN 0
`define HBWU_BIT_MODE 1
`define HBWU_BIT_LOAD 2
`define HBWU_THR_LO 16
`define HBWU_IB_CTRL_MASK 32'h00FF0003
`define HBWU_DW_CTRL_MASK 32'h00FF0007
`define HBWU_RW_CTRL_MASK 32'h00FF0003
`define HBWU_HIT_TYPE_MASK 32'h0003FF07
`define HBWU_STOP_MASK 32'h000000FF
`define HBWU_CAUSE_IB 3'h3
`define HBWU_CAUSE_DW 3'h4
`define HBWU_CAUSE_RW 3'h5
`define HBWU_RESP_OKAY 2'h0
`define HBWU_RESP_SLVERR 2'h2
`define HBWU_RESET_WORD 32'h00000000
`endif

// ===== core/hbwu_pkg.sv
package hbwu_pkg;
   typedef struct packed {
      logic [1:0]  idx;
      logic [7:0]  thread;
      logic [2:0]  cause;
      logic [31:0] data;
      logic        load_data;
   } hbwu_hit_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] value;
      logic [2:0]  thread;
      logic        is_load;
   } hbwu_probe_t;
endpackage : hbwu_pkg

// ===== core/hbwu_top.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "hbwu_defs.svh"

module hbwu_top
   import hbwu_pkg::*;
#(
   parameter int NUM_UNITS = 4
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,

   // AXI4-Lite slave
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,

   // Core probes
   input  wire hbwu_probe_t pc_probe,
   input  wire hbwu_probe_t mem_probe,
   input  wire hbwu_probe_t res_probe,
   input  wire logic        debug_mode,

   // Core control
   output logic [7:0]       thread_hold,
   output logic             debug_irq,
   output logic             irq,

   // Tile configuration scratch port
   input  wire logic        cfg_valid,
   input  wire logic        cfg_write,
   input  wire logic [2:0]  cfg_index,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata
);

   // Byte strobes pick which lanes of the old word change.
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // A unit fires only for the threads that it enables.
   function automatic logic thr_en(input logic [31:0] ctrl, input logic [2:0] thr);
      return ctrl[`HBWU_BIT_EN] & ctrl[`HBWU_THR_LO + thr];
   endfunction : thr_en

   // The lowest set bit wins, which orders simultaneous hits.
   function automatic logic [1:0] low_idx(input logic [3:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int k = 3; k >= 0; k--) begin
         if (v[k]) begin
            r = k[1:0];
         end
      end
      return r;
   endfunction : low_idx

   // Units sit in groups of four consecutive indices.
   function automatic logic in_grp4(input logic [7:0] idx, input logic [7:0] base);
      return idx[7:2] == base[7:2];
   endfunction : in_grp4

   // The scratch words form one group of eight indices.
   function automatic logic in_grp8(input logic [7:0] idx, input logic [7:0] base);
      return idx[7:3] == base[7:3];
   endfunction : in_grp8

   // Register storage.
   logic [31:0] ib_addr_r [NUM_UNITS];
   logic [31:0] ib_ctrl_r [NUM_UNITS];
   logic [31:0] dw_a1_r   [NUM_UNITS];
   logic [31:0] dw_a2_r   [NUM_UNITS];
   logic [31:0] dw_ctrl_r [NUM_UNITS];
   logic [31:0] rw_mask_r [NUM_UNITS];
   logic [31:0] rw_val_r  [NUM_UNITS];
   logic [31:0] rw_ctrl_r [NUM_UNITS];
   logic [31:0] scratch_r [8];

   // Debug record, stop vector and interrupt state.
   logic [31:0] hit_type_r;
   logic [31:0] hit_data_r;
   logic [31:0] core_stop_r;
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_en_r;
   logic        debug_irq_r;
   logic [31:0] cfg_rdata_r;

   // AXI state.
   logic        aw_held_r;
   logic        w_held_r;
   logic [7:0]  aw_idx_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   // Write channel acceptance; the two halves may arrive in either order.
   wire        aw_take  = s_axi_awvalid & ~aw_held_r;
   wire        w_take   = s_axi_wvalid & ~w_held_r;
   wire        wr_go    = aw_held_r & w_held_r & ~bvalid_r;
   wire [7:0]  wi       = aw_idx_r;
   wire        ar_take  = s_axi_arvalid & ~rvalid_r;
   wire [7:0]  ri       = s_axi_araddr[9:2];

   assign s_axi_awready = ~aw_held_r;
   assign s_axi_wready  = ~w_held_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   function automatic logic mapped(input logic [7:0] idx);
      return idx == `HBWU_IDX_HIT_TYPE || idx == `HBWU_IDX_HIT_DATA ||
             idx == `HBWU_IDX_CORE_STOP || in_grp8(idx, `HBWU_IDX_SCRATCH) ||
             in_grp4(idx, `HBWU_IDX_IB_ADDR) || in_grp4(idx, `HBWU_IDX_IB_CTRL) ||
             in_grp4(idx, `HBWU_IDX_DW_A1) || in_grp4(idx, `HBWU_IDX_DW_A2) ||
             in_grp4(idx, `HBWU_IDX_DW_CTRL) || in_grp4(idx, `HBWU_IDX_RW_MASK) ||
             in_grp4(idx, `HBWU_IDX_RW_VAL) || in_grp4(idx, `HBWU_IDX_RW_CTRL) ||
             idx == `HBWU_IDX_IRQ_STAT || idx == `HBWU_IDX_IRQ_CLR ||
             idx == `HBWU_IDX_IRQ_EN;
   endfunction : mapped

   // Unmapped indices answer with an error and change nothing.
   wire        wr_ok  = wr_go & mapped(wi);
   wire [31:0] wmask  = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire [1:0]  wu     = wi[1:0];

   // Read selection; the clear register reads as zero.
   wire [1:0]  ru = ri[1:0];
   wire [31:0] rd_word =
      (ri == `HBWU_IDX_HIT_TYPE)           ? hit_type_r :
      (ri == `HBWU_IDX_HIT_DATA)           ? hit_data_r :
      (ri == `HBWU_IDX_CORE_STOP)          ? core_stop_r :
      in_grp8(ri, `HBWU_IDX_SCRATCH)       ? scratch_r[ri[2:0]] :
      in_grp4(ri, `HBWU_IDX_IB_ADDR)       ? ib_addr_r[ru] :
      in_grp4(ri, `HBWU_IDX_IB_CTRL)       ? ib_ctrl_r[ru] :
      in_grp4(ri, `HBWU_IDX_DW_A1)         ? dw_a1_r[ru] :
      in_grp4(ri, `HBWU_IDX_DW_A2)         ? dw_a2_r[ru] :
      in_grp4(ri, `HBWU_IDX_DW_CTRL)       ? dw_ctrl_r[ru] :
      in_grp4(ri, `HBWU_IDX_RW_MASK)       ? rw_mask_r[ru] :
      in_grp4(ri, `HBWU_IDX_RW_VAL)        ? rw_val_r[ru] :
      in_grp4(ri, `HBWU_IDX_RW_CTRL)       ? rw_ctrl_r[ru] :
      (ri == `HBWU_IDX_IRQ_STAT)           ? {29'h0, irq_stat_r} :
      (ri == `HBWU_IDX_IRQ_EN)             ? {29'h0, irq_en_r} : `HBWU_RESET_WORD;

   // Match logic per unit.
   logic [3:0] ib_hit;
   logic [3:0] dw_hit;
   logic [3:0] rw_hit;

   for (genvar i = 0; i < NUM_UNITS; i++) begin : g_match
      wire pc_eq  = pc_probe.value == ib_addr_r[i];
      wire ib_cnd = ib_ctrl_r[i][`HBWU_BIT_MODE] ? ~pc_eq : pc_eq;
      assign ib_hit[i] = pc_probe.valid & thr_en(ib_ctrl_r[i], pc_probe.thread) & ib_cnd;

      wire dw_a   = mem_probe.value == dw_a1_r[i];
      wire dw_b   = mem_probe.value == dw_a2_r[i];
      wire dw_cnd = dw_ctrl_r[i][`HBWU_BIT_MODE] ? (dw_a | dw_b) : (dw_a & dw_b);
      wire dw_op  = ~mem_probe.is_load | dw_ctrl_r[i][`HBWU_BIT_LOAD];
      assign dw_hit[i] = mem_probe.valid & thr_en(dw_ctrl_r[i], mem_probe.thread) & dw_op & dw_cnd;

      wire rw_eq  = (res_probe.value & rw_mask_r[i]) == rw_val_r[i];
      wire rw_cnd = rw_ctrl_r[i][`HBWU_BIT_MODE] ? ~rw_eq : rw_eq;
      assign rw_hit[i] = res_probe.valid & thr_en(rw_ctrl_r[i], res_probe.thread) & rw_cnd;
   end

   // An instruction breakpoint wins over a data watch, which wins over a resource watch.
   wire        any_ib  = |ib_hit;
   wire        any_dw  = |dw_hit;
   wire        any_rw  = |rw_hit;
   // Hits are ignored in debug mode so the debugger cannot trap itself.
   wire        take    = (any_ib | any_dw | any_rw) & ~debug_mode;
   hbwu_hit_t  rec;
   assign rec.cause     = any_ib ? `HBWU_CAUSE_IB : any_dw ? `HBWU_CAUSE_DW : `HBWU_CAUSE_RW;
   assign rec.idx       = any_ib ? low_idx(ib_hit) : any_dw ? low_idx(dw_hit) : low_idx(rw_hit);
   assign rec.thread    = {5'h0, any_ib ? pc_probe.thread : any_dw ? mem_probe.thread : res_probe.thread};
   assign rec.load_data = ~any_ib;
   assign rec.data      = any_dw ? mem_probe.value : res_probe.value;

   // Status bits are sticky, and an event beats a clear in the same cycle.
   wire [2:0]  irq_set  = take ? {~any_ib & ~any_dw, ~any_ib & any_dw, any_ib} : 3'h0;
   wire [2:0]  irq_clr  = (wr_ok && wi == `HBWU_IDX_IRQ_CLR) ? (w_data_r[2:0] & wmask[2:0]) : 3'h0;
   wire [2:0]  stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

   // The stop vector only holds threads while the processor runs its own code.
   assign thread_hold = debug_mode ? 8'h00 : core_stop_r[7:0];
   assign debug_irq   = debug_irq_r;
   assign irq         = |(irq_stat_r & irq_en_r);
   assign cfg_rdata   = cfg_rdata_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_idx_r  <= 8'h00;
         w_data_r  <= `HBWU_RESET_WORD;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `HBWU_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_idx_r  <= s_axi_awaddr[9:2];
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end

         if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end

         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= mapped(wi) ? `HBWU_RESP_OKAY : `HBWU_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read data is captured at the handshake, so it stands while rvalid waits.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= `HBWU_RESET_WORD;
         rresp_r  <= `HBWU_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= mapped(ri) ? `HBWU_RESP_OKAY : `HBWU_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Control words keep only their defined bits, so reserved bits read zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_UNITS; i++) begin
            ib_addr_r[i] <= `HBWU_RESET_WORD;
            ib_ctrl_r[i] <= `HBWU_RESET_WORD;
            dw_a1_r[i]   <= `HBWU_RESET_WORD;
            dw_a2_r[i]   <= `HBWU_RESET_WORD;
            dw_ctrl_r[i] <= `HBWU_RESET_WORD;
            rw_mask_r[i] <= `HBWU_RESET_WORD;
            rw_val_r[i]  <= `HBWU_RESET_WORD;
            rw_ctrl_r[i] <= `HBWU_RESET_WORD;
         end
      end else if (wr_ok) begin
         if (in_grp4(wi, `HBWU_IDX_IB_ADDR)) begin
            ib_addr_r[wu] <= be_merge(ib_addr_r[wu], w_data_r, w_strb_r);
         end

         if (in_grp4(wi, `HBWU_IDX_IB_CTRL)) begin
            ib_ctrl_r[wu] <= be_merge(ib_ctrl_r[wu], w_data_r, w_strb_r) & `HBWU_IB_CTRL_MASK;
         end

         if (in_grp4(wi, `HBWU_IDX_DW_A1)) begin
            dw_a1_r[wu] <= be_merge(dw_a1_r[wu], w_data_r, w_strb_r);
         end

         if (in_grp4(wi, `HBWU_IDX_DW_A2)) begin
            dw_a2_r[wu] <= be_merge(dw_a2_r[wu], w_data_r, w_strb_r);
         end

         if (in_grp4(wi, `HBWU_IDX_DW_CTRL)) begin
            dw_ctrl_r[wu] <= be_merge(dw_ctrl_r[wu], w_data_r, w_strb_r) & `HBWU_DW_CTRL_MASK;
         end

         if (in_grp4(wi, `HBWU_IDX_RW_MASK)) begin
            rw_mask_r[wu] <= be_merge(rw_mask_r[wu], w_data_r, w_strb_r);
         end

         if (in_grp4(wi, `HBWU_IDX_RW_VAL)) begin
            rw_val_r[wu] <= be_merge(rw_val_r[wu], w_data_r, w_strb_r);
         end

         if (in_grp4(wi, `HBWU_IDX_RW_CTRL)) begin
            rw_ctrl_r[wu] <= be_merge(rw_ctrl_r[wu], w_data_r, w_strb_r) & `HBWU_RW_CTRL_MASK;
         end
      end
   end

   // Scratch words: the bus write wins when both ports hit the same word in one cycle.
   wire       ax_scr  = wr_ok && in_grp8(wi, `HBWU_IDX_SCRATCH);
   wire       cf_wr   = cfg_valid & cfg_write & ~(ax_scr && wi[2:0] == cfg_index);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < 8; k++) begin
            scratch_r[k] <= `HBWU_RESET_WORD;
         end
         cfg_rdata_r <= `HBWU_RESET_WORD;
      end else begin
         if (ax_scr) begin
            scratch_r[wi[2:0]] <= be_merge(scratch_r[wi[2:0]], w_data_r, w_strb_r);
         end

         if (cf_wr) begin
            scratch_r[cfg_index] <= cfg_wdata;
         end

         if (cfg_valid & ~cfg_write) begin
            cfg_rdata_r <= scratch_r[cfg_index];
         end
      end
   end

   // A hit in the same cycle as a software write to the hit type takes precedence; for hit data, only data and resource watch hits do.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit_type_r  <= `HBWU_RESET_WORD;
         hit_data_r  <= `HBWU_RESET_WORD;
         core_stop_r <= `HBWU_RESET_WORD;
         irq_stat_r  <= 3'h0;
         irq_en_r    <= 3'h0;
         debug_irq_r <= 1'b0;
      end else begin
         debug_irq_r <= take;
         irq_stat_r  <= stat_nxt;

         if (take) begin
            hit_type_r <= {14'h0, rec.idx, rec.thread, 5'h0, rec.cause};
         end else if (wr_ok && wi == `HBWU_IDX_HIT_TYPE) begin
            hit_type_r <= be_merge(hit_type_r, w_data_r, w_strb_r) & `HBWU_HIT_TYPE_MASK;
         end

         if (take && rec.load_data) begin
            hit_data_r <= rec.data;
         end else if (wr_ok && wi == `HBWU_IDX_HIT_DATA) begin
            hit_data_r <= be_merge(hit_data_r, w_data_r, w_strb_r);
         end

         if (wr_ok && wi == `HBWU_IDX_CORE_STOP) begin
            core_stop_r <= be_merge(core_stop_r, w_data_r, w_strb_r) & `HBWU_STOP_MASK;
         end

         if (wr_ok && wi == `HBWU_IDX_IRQ_EN) begin
            irq_en_r <= (w_data_r[2:0] & wmask[2:0]) | (irq_en_r & ~wmask[2:0]);
         end
      end
   end

endmodule : hbwu_top

// ===== dv/hbwu_top_asserts.sv
`timescale 1ns/1ps
`include "hbwu_defs.svh"
module hbwu_top_asserts
   import hbwu_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Core side
   input wire hbwu_probe_t pc_probe,
   input wire hbwu_probe_t mem_probe,
   input wire hbwu_probe_t res_probe,
   input wire logic        debug_mode,
   input wire logic [7:0]  thread_hold,
   input wire logic        debug_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic any_probe = pc_probe.valid || mem_probe.valid || res_probe.valid;

   property p_hold_dbg; debug_mode |-> thread_hold == 8'h00; endproperty
   property p_irq_src; debug_irq |-> $past(any_probe && !debug_mode); endproperty
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_aw_take; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
   property p_err_zero; s_axi_rvalid && s_axi_rresp == `HBWU_RESP_SLVERR |-> s_axi_rdata == 32'h00000000; endproperty

   a_hold_dbg: assert property (p_hold_dbg) else $error("hold while debugging");
   a_irq_src: assert property (p_irq_src) else $error("debug irq without hit");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   a_r_done: assert property (p_r_done) else $error("read response repeated");
   a_r_next: assert property (p_r_next) else $error("read answer late");
   a_aw_take: assert property (p_aw_take) else $error("address ready not dropped");
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");

   c_irq: cover property (debug_irq);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == `HBWU_RESP_SLVERR);
   c_hold: cover property (thread_hold != 8'h00 ##1 debug_mode);
endmodule : hbwu_top_asserts

bind hbwu_top hbwu_top_asserts chk_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pc_probe(pc_probe), .mem_probe(mem_probe), .res_probe(res_probe), .debug_mode(debug_mode),
   .thread_hold(thread_hold), .debug_irq(debug_irq)
);

// ===== dv/hbwu_core_model.sv
`timescale 1ns/1ps
module hbwu_core_model
   import hbwu_pkg::*;
(
   // Clock
   input  wire logic   aclk,
   // Core probes
   output hbwu_probe_t pc_probe,
   output hbwu_probe_t mem_probe,
   output hbwu_probe_t res_probe,
   output logic        debug_mode
);
   initial begin
      pc_probe = '0;
      mem_probe = '0;
      res_probe = '0;
      debug_mode = 1'b0;
   end

   // Every probe carries the value, only the chosen one is valid; idle probes then show the
   // inverse so that a unit which ignores valid is caught.
   task automatic issue(input int k, input logic [31:0] v, input logic [2:0] t, input logic ld);
      @(posedge aclk);
      pc_probe <= '{k == 0, v, t, ld};
      mem_probe <= '{k == 1, v, t, ld};
      res_probe <= '{k == 2, v, t, ld};
      @(posedge aclk);
      pc_probe <= '{1'b0, ~v, ~t, ~ld};
      mem_probe <= '{1'b0, ~v, ~t, ~ld};
      res_probe <= '{1'b0, ~v, ~t, ~ld};
   endtask : issue

   task automatic set_mode(input logic m);
      @(posedge aclk);
      debug_mode <= m;
   endtask : set_mode
endmodule : hbwu_core_model

// ===== dv/hbwu_top_tb.sv
`timescale 1ns/1ps
`include "hbwu_defs.svh"
module hbwu_top_tb
   import hbwu_pkg::*;
;
   logic             aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
   logic             arv = 1'b0, rready = 1'b0, cfg_valid = 1'b0, cfg_write = 1'b0;
   logic [9:0]       awaddr = '0, araddr = '0;
   logic [31:0]      wdata = '0, cfg_wdata = '0, rd, x, seed = 32'hC8567FC8;
   logic [2:0]       cfg_index = '0, t;
   logic [3:0]       wstrb = 4'hF;
   logic [1:0]       rs;
   wire logic        awready, wready, bvalid, arready, rvalid, debug_irq, irq, debug_mode;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata, cfg_rdata;
   wire logic [7:0]  thread_hold;
   wire hbwu_probe_t pc_probe, mem_probe, res_probe;
   int               fails = 0, compares = 0;

   hbwu_top dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pc_probe(pc_probe), .mem_probe(mem_probe), .res_probe(res_probe),
      .debug_mode(debug_mode), .thread_hold(thread_hold), .debug_irq(debug_irq), .irq(irq),
      .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata)
   );
   hbwu_core_model core_u (.aclk(aclk), .pc_probe(pc_probe), .mem_probe(mem_probe),
      .res_probe(res_probe), .debug_mode(debug_mode));

   initial begin
      forever #2 aclk = ~aclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   function automatic logic [31:0] hw(input logic [1:0] i, input logic [2:0] th, input logic [2:0] c);
      return {14'h0000, i, 5'h00, th, 5'h00, c};
   endfunction : hw

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   // A response ready that starts low half the time exercises the slave's hold of its answer.
   task automatic axw(input logic [7:0] i, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= {i, 2'b00};
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= seed[0];
      forever begin
         @(posedge aclk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         if (bvalid && bready) break;
         if (bvalid) bready <= 1'b1;
      end
      rs = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= {i, 2'b00};
      arv <= 1'b1;
      rready <= seed[1];
      forever begin
         @(posedge aclk);
         if (arready) arv <= 1'b0;
         if (rvalid && rready) break;
         if (rvalid) rready <= 1'b1;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr

   task automatic axc(input logic [7:0] i, input logic [31:0] e);
      axr(i, rd, rs);
      chk(rd, e);
   endtask : axc

   task automatic cfg(input logic w, input logic [2:0] i, input logic [31:0] d);
      @(posedge aclk);
      cfg_valid <= 1'b1;
      cfg_write <= w;
      cfg_index <= i;
      cfg_wdata <= d;
      @(posedge aclk);
      cfg_valid <= 1'b0;
      #1;
   endtask : cfg

   task automatic hit(input int k, input logic [31:0] v, input logic [2:0] th, input logic ld, input logic e);
      core_u.issue(k, v, th, ld);
      #1;
      chk(32'(debug_irq), 32'(e));
   endtask : hit

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (logic [7:0] j = 8'h00; j < 8'h04; j++) begin
         axc(8'h40 + j, 32'h0);
         axc(8'h70 + j, 32'h0);
         axc(8'h9C + j, 32'h0);
      end
      for (logic [7:0] j = 8'h00; j < 8'h08; j++) begin
         seed = lfsr(seed);
         axw(8'h20 + j, seed);
         cfg(1'b0, j[2:0], 32'h0);
         chk(cfg_rdata, seed);
         cfg(1'b1, j[2:0], ~seed);
         axc(8'h20 + j, ~seed);
      end
      wstrb <= 4'h2;
      axw(8'h27, 32'h0);
      wstrb <= 4'hF;
      axc(8'h27, ~seed & 32'hFFFF00FF);
      seed = lfsr(seed);
      axw(8'h18, seed);
      chk(32'(thread_hold), 32'(seed[7:0]));
      axc(8'h18, seed & `HBWU_STOP_MASK);
      core_u.set_mode(1'b1);
      #1;
      chk(32'(thread_hold), 32'h0);
      core_u.set_mode(1'b0);
      #1;
      chk(32'(thread_hold), 32'(seed[7:0]));
      axw(8'h10, seed);
      chk(32'(rs), 32'(`HBWU_RESP_SLVERR));
      axr(8'h10, rd, rs);
      chk(32'(rs), 32'(`HBWU_RESP_SLVERR));
      axw(`HBWU_IDX_IRQ_EN, 32'h7);
      for (logic [7:0] j = 8'h00; j < 8'h04; j++) begin
         seed = lfsr(seed);
         t = seed[2:0];
         axw(8'h30 + j, seed);
         axw(8'h40 + j, (32'h1 << (16 + t)) | 32'h1);
         hit(0, seed, t + 3'h1, 1'b0, 1'b0);
         hit(0, seed, t, 1'b0, 1'b1);
         axc(`HBWU_IDX_HIT_TYPE, hw(j[1:0], t, 3'h3));
         chk(32'(irq), 32'h1);
         axw(`HBWU_IDX_IRQ_CLR, 32'h1);
         chk(32'(irq), 32'h0);
         axw(8'h40 + j, 32'h0);
      end
      x = seed;
      axw(8'h31, x);
      axw(8'h32, x);
      axw(8'h41, 32'h00200001);
      axw(8'h42, 32'h00200001);
      hit(0, x, 3'h5, 1'b0, 1'b1);
      axc(`HBWU_IDX_HIT_TYPE, hw(2'h1, 3'h5, 3'h3));
      axw(8'h41, 32'h00200003);
      hit(0, x, 3'h5, 1'b0, 1'b1);
      axc(`HBWU_IDX_HIT_TYPE, hw(2'h2, 3'h5, 3'h3));
      hit(0, x + 32'h4, 3'h5, 1'b0, 1'b1);
      axc(`HBWU_IDX_HIT_TYPE, hw(2'h1, 3'h5, 3'h3));
      axw(8'h41, 32'h0);
      axw(8'h42, 32'h0);
      axw(8'h52, x);
      axw(8'h62, x + 32'h8);
      axw(8'h72, 32'h00080001);
      hit(1, x, 3'h3, 1'b0, 1'b0);
      axw(8'h72, 32'h00080003);
      hit(1, x, 3'h3, 1'b1, 1'b0);
      hit(1, x, 3'h3, 1'b0, 1'b1);
      axc(`HBWU_IDX_HIT_DATA, x);
      axc(`HBWU_IDX_HIT_TYPE, hw(2'h2, 3'h3, 3'h4));
      axw(8'h72, 32'hFFFFFFFF);
      axc(8'h72, `HBWU_DW_CTRL_MASK);
      hit(1, x + 32'h8, 3'h6, 1'b1, 1'b1);
      axc(`HBWU_IDX_HIT_DATA, x + 32'h8);
      axw(8'h72, 32'h0);
      axw(`HBWU_IDX_IRQ_CLR, 32'h7);
      axw(`HBWU_IDX_IRQ_EN, 32'h0);
      axw(8'h81, 32'h0000FF00);
      axw(8'h91, 32'h00002A00);
      axw(8'h9D, 32'h00010001);
      hit(2, 32'h12342A77, 3'h0, 1'b0, 1'b1);
      axc(`HBWU_IDX_HIT_DATA, 32'h12342A77);
      axc(`HBWU_IDX_HIT_TYPE, hw(2'h1, 3'h0, 3'h5));
      chk(32'(irq), 32'h0);
      axc(`HBWU_IDX_IRQ_STAT, 32'h4);
      axw(8'h9D, 32'h00010003);
      hit(2, 32'h12342A77, 3'h0, 1'b0, 1'b0);
      hit(2, 32'h00001100, 3'h0, 1'b0, 1'b1);
      core_u.set_mode(1'b1);
      hit(2, 32'h00001100, 3'h0, 1'b0, 1'b0);
      test_done();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      test_done();
   end
endmodule : hbwu_top_tb
